// [mau_top.sv]
`timescale 1ns/100ps
module mau_top #(
    parameter mau_pkg::mau_op_type OP_MODE = mau_pkg::MAU_OP_SEL,
    parameter bit                  HAS_EN  = 1'b1,
    parameter bit                  FLOAT   = 1'b0,
    parameter int                  LATENCY = -1
) (
    input  wire logic                         CLK_I,
    input  wire logic                         SRST_I,
    input  wire logic                         PSEL_I,
    input  wire logic                         PENABLE_I,
    input  wire logic                         PWRITE_I,
    input  wire logic [mau_pkg::ADDR_W-1:0]   PADDR_I,
    input  wire logic [mau_pkg::DATA_W-1:0]   PWDATA_I,
    input  wire logic [3:0]                   PSTRB_I,
    output logic      [mau_pkg::DATA_W-1:0]   PRDATA_O,
    output logic                              PREADY_O,
    output logic                              PSLVERR_O
);
    localparam int DEPTH  = mau_pkg::depth_of(FLOAT, LATENCY);
    localparam bit CFG_OK = mau_pkg::latency_ok(FLOAT, HAS_EN, LATENCY);
    localparam logic [7:0] DEPTH_B = 8'(DEPTH);

    logic [mau_pkg::DATA_W-1:0] opa_reg;
    logic [mau_pkg::DATA_W-1:0] opb_reg;
    logic [mau_pkg::DATA_W-1:0] opc_reg;
    logic [mau_pkg::DATA_W-1:0] ctrl_reg;
    logic [mau_pkg::DATA_W-1:0] prdata_reg;
    logic [mau_pkg::DATA_W-1:0] prdata_next;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic                       pslverr_next;
    logic [7:0]                 fill_reg;
    logic [7:0]                 run_reg;
    logic                       setup;
    logic                       wr_take;
    logic                       adv;
    logic                       sub_eff;
    logic                       prec_user;
    mau_pkg::mau_ops_type       ops;
    logic [mau_pkg::FULL_W-1:0] raw;
    logic [mau_pkg::FULL_W-1:0] pipe_q;
    logic [mau_pkg::FULL_W-1:0] pipe_d;
    logic [mau_pkg::FULL_W-1:0] fmt;
    logic [mau_pkg::DATA_W-1:0] status;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    // rescale to the chosen fraction, cut to the chosen width, then extend by type
    function automatic logic [33:0] quantize(input logic [33:0] x, input int shift,
                                             input int obits, input logic sgn);
        logic [33:0] v;
        int          nb;
        v  = '0;
        nb = (obits < 1 || obits > mau_pkg::FULL_W) ? mau_pkg::FULL_W : obits;
        if (shift >= 0) begin
            v = sgn ? 34'($signed(x) >>> shift) : 34'(x >> shift);
        end else begin
            v = 34'(x << (-shift));
        end
        for (int i = 0; i < mau_pkg::FULL_W; i++) begin
            if (i >= nb) begin
                v[i] = sgn & v[nb-1];
            end
        end
        return v;
    endfunction

    // apb phases: writes are taken only in an access cycle that shows ready
    assign setup   = PSEL_I & ~PENABLE_I;
    assign wr_take = PSEL_I & PENABLE_I & PWRITE_I & pready_reg;

    // one wait-free access phase: ready rises in the first access cycle
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    // operand registers feed the datapath every sample period
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            opa_reg <= mau_pkg::OPA_RST;
            opb_reg <= mau_pkg::OPB_RST;
            opc_reg <= mau_pkg::OPC_RST;
        end else if (wr_take) begin
            if (PADDR_I == mau_pkg::OPA_OFS) begin
                opa_reg <= merge_strb(opa_reg, PWDATA_I, PSTRB_I) & 32'h0000_FFFF;
            end
            if (PADDR_I == mau_pkg::OPB_OFS) begin
                opb_reg <= merge_strb(opb_reg, PWDATA_I, PSTRB_I) & 32'h0000_FFFF;
            end
            if (PADDR_I == mau_pkg::OPC_OFS) begin
                opc_reg <= merge_strb(opc_reg, PWDATA_I, PSTRB_I);
            end
        end
    end

    // control register: subtract, enable, type and output precision
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ctrl_reg <= mau_pkg::CTRL_RST;
        end else if (wr_take && PADDR_I == mau_pkg::CTRL_OFS) begin
            ctrl_reg <= merge_strb(ctrl_reg, PWDATA_I, PSTRB_I) & 32'h03FF_FFFF;
        end
    end

    // operation choice is fixed by configuration except in the selectable one
    always_comb begin
        case (OP_MODE)
            mau_pkg::MAU_OP_ADD: sub_eff = 1'b0;
            mau_pkg::MAU_OP_SUB: sub_eff = 1'b1;
            mau_pkg::MAU_OP_SEL: sub_eff = ctrl_reg[mau_pkg::CTRL_SUB_BIT];
            default:             sub_eff = 1'b0;
        endcase
    end

    // an illegal latency setting keeps the unit frozen rather than run mistimed
    assign adv = CFG_OK & (~HAS_EN | ctrl_reg[mau_pkg::CTRL_EN_BIT]);

    // operand bundle; c is taken as already aligned by the neighbours
    always_comb begin
        ops.a   = opa_reg[mau_pkg::A_W-1:0];
        ops.b   = opb_reg[mau_pkg::B_W-1:0];
        ops.c   = opc_reg;
        ops.sub = sub_eff;
        ops.sgn = ctrl_reg[mau_pkg::CTRL_SGN_BIT];
    end

    mau_mul_add i_mau_mul_add (
        .ops_i (ops),
        .sum_o (raw)
    );

    // a refused setting shows zero, even on a path with no registers to freeze
    assign pipe_d = CFG_OK ? raw : '0;

    mau_pipe #(
        .DEPTH (DEPTH)
    ) i_mau_pipe (
        .clk_i  (CLK_I),
        .srst_i (SRST_I),
        .adv_i  (adv),
        .d_i    (pipe_d),
        .q_o    (pipe_q)
    );

    // output precision: float ignores the user setting and stays full
    assign prec_user = ctrl_reg[mau_pkg::CTRL_USER_BIT] & ~FLOAT;
    always_comb begin
        if (prec_user) begin
            fmt = quantize(pipe_q,
                           int'(ctrl_reg[mau_pkg::CTRL_FA_LSB +: mau_pkg::FRAC_W])
                         + int'(ctrl_reg[mau_pkg::CTRL_FB_LSB +: mau_pkg::FRAC_W])
                         - int'(ctrl_reg[mau_pkg::CTRL_OFRAC_LSB +: mau_pkg::OBITS_W]),
                           int'(ctrl_reg[mau_pkg::CTRL_OBITS_LSB +: mau_pkg::OBITS_W]),
                           ctrl_reg[mau_pkg::CTRL_SGN_BIT]);
        end else begin
            fmt = pipe_q;
        end
    end

    // fill level: tells software the pipeline has seen a full latency of samples
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            fill_reg <= 8'h00;
        end else if (adv && fill_reg < DEPTH_B) begin
            fill_reg <= fill_reg + 8'h01;
        end
    end

    // consecutive advancing cycles, saturating
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            run_reg <= 8'h00;
        end else if (!adv) begin
            run_reg <= 8'h00;
        end else if (run_reg != 8'hFF) begin
            run_reg <= run_reg + 8'h01;
        end
    end

    always_comb begin
        status = '0;
        status[mau_pkg::STAT_OK_BIT]            = CFG_OK;
        status[mau_pkg::STAT_EN_BIT]            = HAS_EN;
        status[mau_pkg::STAT_FLT_BIT]           = FLOAT;
        status[mau_pkg::STAT_PRIMED_BIT]        = (fill_reg == DEPTH_B);
        status[mau_pkg::STAT_MODE_LSB +: 2]     = OP_MODE;
        status[mau_pkg::STAT_DEPTH_LSB +: 8]    = DEPTH_B;
    end

    // read decode; an unmapped address reads zero and flags an error
    always_comb begin
        prdata_next  = '0;
        pslverr_next = 1'b0;
        case (PADDR_I)
            mau_pkg::OPA_OFS:    prdata_next = opa_reg;
            mau_pkg::OPB_OFS:    prdata_next = opb_reg;
            mau_pkg::OPC_OFS:    prdata_next = opc_reg;
            mau_pkg::CTRL_OFS:   prdata_next = ctrl_reg;
            mau_pkg::RESLO_OFS:  prdata_next = fmt[31:0];
            mau_pkg::RESHI_OFS:  prdata_next = {30'h0, fmt[33:32]};
            mau_pkg::STATUS_OFS: prdata_next = status;
            default:             pslverr_next = 1'b1;
        endcase
    end

    // answer captured at the setup edge so the bus outputs come from flops
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= PWRITE_I ? 32'h0000_0000 : prdata_next;
            pslverr_reg <= pslverr_next;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    assign PRDATA_O  = prdata_reg;
    assign PREADY_O  = pready_reg;
    assign PSLVERR_O = pslverr_reg;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence

    sequence s_ready;
        PREADY_O;
    endsequence

    apb_ready_a: assert property (s_setup |=> s_ready)
        else $error("ready did not follow setup");

    sequence s_error;
        PSLVERR_O && PREADY_O;
    endsequence

    ready_pulse_a: assert property (s_ready |=> !PREADY_O)
        else $error("ready stood longer than one cycle");

    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error flag without ready");

    rdata_hold_a: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
        else $error("read data moved outside a setup edge");

    unmapped_err_a: assert property (s_setup ##0 (PADDR_I > mau_pkg::STATUS_OFS) |=> s_error)
        else $error("unmapped address not refused");

    // register checks: full-word opc writes land whole, refused ones leave everything alone
    wr_land_a: assert property (wr_take && PADDR_I == mau_pkg::OPC_OFS && PSTRB_I == 4'hF
            |=> opc_reg == $past(PWDATA_I))
        else $error("full-word write did not land");

    refused_write_a: assert property (wr_take && PADDR_I >= mau_pkg::RESLO_OFS
            |=> $stable(opa_reg) && $stable(opb_reg) && $stable(opc_reg) && $stable(ctrl_reg))
        else $error("refused write changed a register");

    spare_zero_a: assert property (ctrl_reg[31:26] == 6'h00 && opa_reg[31:16] == 16'h0000
            && opb_reg[31:16] == 16'h0000)
        else $error("spare register bits set");

    mul_add_a: assert property (!ops.sgn |-> raw == (ops.sub ?
            34'(ops.a) * 34'(ops.b) - 34'(ops.c) : 34'(ops.a) * 34'(ops.b) + 34'(ops.c)))
        else $error("datapath result wrong");

    add_fixed_a: assert property (OP_MODE == mau_pkg::MAU_OP_ADD |-> !ops.sub)
        else $error("add mode subtracted");

    sub_fixed_a: assert property (OP_MODE == mau_pkg::MAU_OP_SUB |-> ops.sub)
        else $error("subtract mode added");

    sub_select_a: assert property (OP_MODE == mau_pkg::MAU_OP_SEL |->
            ops.sub == ctrl_reg[mau_pkg::CTRL_SUB_BIT])
        else $error("subtract select ignored");

    enable_gate_a: assert property (HAS_EN && !ctrl_reg[mau_pkg::CTRL_EN_BIT] |-> !adv)
        else $error("advanced while disabled");

    bad_cfg_a: assert property (!CFG_OK |=> $stable(pipe_q))
        else $error("illegal latency setting ran");

    full_prec_a: assert property (!ctrl_reg[mau_pkg::CTRL_USER_BIT] || FLOAT |-> fmt == pipe_q)
        else $error("full precision altered");

    unsigned_out_a: assert property (prec_user && !ctrl_reg[mau_pkg::CTRL_SGN_BIT]
            && ctrl_reg[mau_pkg::CTRL_OBITS_LSB +: mau_pkg::OBITS_W] == 6'h08
            |-> fmt[33:8] == 26'h0)
        else $error("unsigned output not zero-extended");

    user_sext_a: assert property (prec_user && ctrl_reg[mau_pkg::CTRL_SGN_BIT]
            && ctrl_reg[mau_pkg::CTRL_OBITS_LSB +: mau_pkg::OBITS_W] == 6'h08
            |-> fmt[33:8] == {26{fmt[7]}})
        else $error("signed output not sign-extended");

    refused_zero_a: assert property (!CFG_OK |-> pipe_q == '0)
        else $error("refused setting produced a result");

    comb_path_a: assert property (DEPTH == 0 && CFG_OK |-> pipe_q == raw)
        else $error("zero latency path delayed");

    generate
        if (DEPTH > 0) begin : g_lat_chk
            hold_regs_a: assert property (!adv |=> $stable(pipe_q))
                else $error("pipeline moved while held");

            latency_a: assert property (run_reg >= DEPTH_B |-> pipe_q == $past(raw, DEPTH))
                else $error("latency mismatch");
        end
    endgenerate
endmodule

// [mau_pkg.sv]
package mau_pkg;

    // operand and result widths
    localparam int A_W    = 16;
    localparam int B_W    = 16;
    localparam int C_W    = 32;
    localparam int FULL_W = 34;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // pipeline depth used for the "optimal" fixed-point latency setting
    localparam int OPT_DEPTH = 3;
    localparam int LAT_OPT   = -1;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OPA_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] OPB_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] OPC_OFS    = 8'h08;
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h0C;
    localparam logic [ADDR_W-1:0] RESLO_OFS  = 8'h10;
    localparam logic [ADDR_W-1:0] RESHI_OFS  = 8'h14;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;

    // control register fields
    localparam int CTRL_SUB_BIT   = 0;
    localparam int CTRL_EN_BIT    = 1;
    localparam int CTRL_SGN_BIT   = 2;
    localparam int CTRL_USER_BIT  = 3;
    localparam int CTRL_OBITS_LSB = 4;
    localparam int CTRL_OFRAC_LSB = 10;
    localparam int CTRL_FA_LSB    = 16;
    localparam int CTRL_FB_LSB    = 21;
    localparam int OBITS_W        = 6;
    localparam int FRAC_W         = 5;

    // status register fields
    localparam int STAT_OK_BIT     = 0;
    localparam int STAT_EN_BIT     = 1;
    localparam int STAT_FLT_BIT    = 2;
    localparam int STAT_PRIMED_BIT = 3;
    localparam int STAT_MODE_LSB   = 4;
    localparam int STAT_DEPTH_LSB  = 8;

    // reset values: signed, full precision, 34 output bits, disabled
    localparam logic [DATA_W-1:0] OPA_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OPB_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OPC_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0224;

    typedef enum logic [1:0] {
        MAU_OP_ADD = 2'b00,
        MAU_OP_SUB = 2'b01,
        MAU_OP_SEL = 2'b11
    } mau_op_type;

    typedef struct packed {
        logic [A_W-1:0] a;
        logic [B_W-1:0] b;
        logic [C_W-1:0] c;
        logic           sub;
        logic           sgn;
    } mau_ops_type;

    // legal latency settings per arithmetic and enable choice
    function automatic logic latency_ok(input logic flt, input logic has_en, input int lat);
        if (flt) begin
            return has_en ? (lat > 0) : (lat >= 0);
        end
        return has_en ? (lat == LAT_OPT) : (lat == 0 || lat == LAT_OPT);
    endfunction

    // register stages implied by a latency setting
    function automatic int depth_of(input logic flt, input int lat);
        if (!flt && lat == LAT_OPT) begin
            return OPT_DEPTH;
        end
        return (lat > 0) ? lat : 0;
    endfunction

endpackage

// [mau_mul_add.sv]
`timescale 1ns/100ps
module mau_mul_add (
    input  wire mau_pkg::mau_ops_type         ops_i,
    output logic [mau_pkg::FULL_W-1:0]        sum_o
);
    logic signed [mau_pkg::A_W:0]      a_x;
    logic signed [mau_pkg::B_W:0]      b_x;
    logic signed [mau_pkg::FULL_W-1:0] prod;
    logic signed [mau_pkg::FULL_W-1:0] c_x;

    // one extra bit carries sign or zero so one signed multiplier serves both types
    always_comb begin
        a_x   = {ops_i.sgn & ops_i.a[mau_pkg::A_W-1], ops_i.a};
        b_x   = {ops_i.sgn & ops_i.b[mau_pkg::B_W-1], ops_i.b};
        prod  = a_x * b_x;
        c_x   = {{(mau_pkg::FULL_W-mau_pkg::C_W){ops_i.sgn & ops_i.c[mau_pkg::C_W-1]}},
                 ops_i.c};
        sum_o = ops_i.sub ? prod - c_x : prod + c_x;
    end
endmodule

// [mau_pipe.sv]
`timescale 1ns/100ps
module mau_pipe #(
    parameter int DEPTH = 3
) (
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    input  wire logic                         adv_i,
    input  wire logic [mau_pkg::FULL_W-1:0]   d_i,
    output logic      [mau_pkg::FULL_W-1:0]   q_o
);
    generate
        if (DEPTH == 0) begin : g_comb
            // zero latency: a purely combinational path
            assign q_o = d_i;
        end else begin : g_regs
            logic [mau_pkg::FULL_W-1:0] stage_reg [DEPTH];

            // every stage shifts only when the unit advances
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    for (int i = 0; i < DEPTH; i++) begin
                        stage_reg[i] <= '0;
                    end
                end else if (adv_i) begin
                    stage_reg[0] <= d_i;
                    for (int i = 1; i < DEPTH; i++) begin
                        stage_reg[i] <= stage_reg[i-1];
                    end
                end
            end
            assign q_o = stage_reg[DEPTH-1];
        end
    endgenerate
endmodule

// [mau_apb_master.sv]
`timescale 1ns/100ps
// register-bus master standing in for the software side of the unit
module mau_apb_master (
    input  wire logic                       clk_i,
    output logic                            psel_o,
    output logic                            penable_o,
    output logic                            pwrite_o,
    output logic [mau_pkg::ADDR_W-1:0]      paddr_o,
    output logic [mau_pkg::DATA_W-1:0]      pwdata_o,
    output logic [3:0]                      pstrb_o,
    input  wire logic [mau_pkg::DATA_W-1:0] prdata_i,
    input  wire logic                       pready_i,
    input  wire logic                       pslverr_i
);
    // idle bus at time zero
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0000_0000;
        pstrb_o   = 4'h0;
    end

    // one transfer; the request is held until ready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= wr;
        paddr_o   <= a;
        pwdata_o  <= d;
        pstrb_o   <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        // released lines carry inverted junk so stale values never look valid
        paddr_o   <= ~a;
        pwdata_o  <= ~d;
    endtask
endmodule

// [mau_top_test.sv]
`timescale 1ns/100ps
// five configurations of the unit share one bus master, selected by tgt
module mau_top_test;
    localparam int         NK = 5;
    localparam logic [1:0] OPM [NK] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h3};
    localparam bit         HEN [NK] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam bit         FLT [NK] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam int         LAT [NK] = '{-1, 0, 2, 0, 0};

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prd [NK];
    logic        rdy [NK];
    logic        serr [NK];
    int          tgt = 0;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    mau_apb_master i_mau_apb_master (
        .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
        .prdata_i(prd[tgt]), .pready_i(rdy[tgt]), .pslverr_i(serr[tgt])
    );

    // select is gated per instance so only the target sees a transfer
    for (genvar k = 0; k < NK; k++) begin : g_dut
        mau_top #(
            .OP_MODE(mau_pkg::mau_op_type'(OPM[k])), .HAS_EN(HEN[k]),
            .FLOAT(FLT[k]), .LATENCY(LAT[k])
        ) i_mau_top (
            .CLK_I(clk), .SRST_I(srst), .PSEL_I(psel && tgt == k),
            .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
            .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prd[k]),
            .PREADY_O(rdy[k]), .PSLVERR_O(serr[k])
        );
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang is cut short well after the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // writes and reads; every address above the status word must be refused
    task automatic wr(input int k, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        logic [31:0] q;
        logic        e;
        tgt <= k;
        i_mau_apb_master.xfer(1'b1, a, d, s, q, e);
        chk("write error flag", {31'h0, e}, {31'h0, a > mau_pkg::STATUS_OFS});
    endtask

    task automatic rd(input int k, input logic [7:0] a, output logic [31:0] q);
        logic e;
        tgt <= k;
        i_mau_apb_master.xfer(1'b0, a, 32'h0000_0000, 4'h0, q, e);
        chk("read error flag", {31'h0, e}, {31'h0, a > mau_pkg::STATUS_OFS});
    endtask

    task automatic res(input int k, input logic [33:0] e, input string what);
        logic [31:0] q;
        rd(k, mau_pkg::RESLO_OFS, q);
        chk(what, q, e[31:0]);
        rd(k, mau_pkg::RESHI_OFS, q);
        chk(what, q, {30'h0, e[33:32]});
    endtask

    // load operands and control, let the pipeline settle, then judge
    task automatic cas(input int k, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] c, input logic [31:0] ctl,
                       input logic [33:0] e, input string what);
        wr(k, mau_pkg::OPA_OFS, a);
        wr(k, mau_pkg::OPB_OFS, b);
        wr(k, mau_pkg::OPC_OFS, c);
        wr(k, mau_pkg::CTRL_OFS, ctl);
        repeat (8) @(posedge clk);
        res(k, e, what);
    endtask

    // primed bit is masked: a zero-depth path always shows it set
    task automatic stat(input int k, input logic [31:0] e);
        logic [31:0] q;
        rd(k, mau_pkg::STATUS_OFS, q);
        chk("status", q & 32'h0000_FFF7, e);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        rd(0, mau_pkg::CTRL_OFS, q);
        chk("ctrl reset", q, mau_pkg::CTRL_RST);
        rd(0, mau_pkg::OPC_OFS, q);
        chk("opc reset", q, mau_pkg::OPC_RST);
        res(0, 34'h0_0000_0000, "result reset");
        rd(0, mau_pkg::STATUS_OFS, q);
        chk("status reset", q, 32'h0000_0333);
        $display("test reset done");
    endtask

    task automatic t_arith();
        cas(0, 32'h3, 32'h5, 32'h7, 32'h226, 34'h0_0000_0016, "sel add");
        cas(0, 32'h3, 32'h5, 32'h7, 32'h227, 34'h0_0000_0008, "sel sub");
        cas(0, 32'hFFFE, 32'h3, 32'h0, 32'h226, 34'h3_FFFF_FFFA, "signed");
        cas(0, 32'hFFFE, 32'h3, 32'h0, 32'h222, 34'h0_0002_FFFA, "unsigned");
        cas(0, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF, 32'h222, 34'h1_FFFE_0000, "full u");
        cas(0, 32'h8000, 32'h8000, 32'h4000_0000, 32'h226, 34'h0_8000_0000, "full s");
        $display("test arith done");
    endtask

    task automatic t_timing();
        cas(0, 32'h3, 32'h5, 32'h7, 32'h226, 34'h0_0000_0016, "base");
        wr(0, mau_pkg::OPC_OFS, 32'h9);
        res(0, 34'h0_0000_0016, "not yet through");
        repeat (4) @(posedge clk);
        res(0, 34'h0_0000_0018, "through");
        wr(0, mau_pkg::CTRL_OFS, 32'h224);
        wr(0, mau_pkg::OPA_OFS, 32'h4);
        repeat (8) @(posedge clk);
        res(0, 34'h0_0000_0018, "held");
        wr(0, mau_pkg::CTRL_OFS, 32'h226);
        repeat (8) @(posedge clk);
        res(0, 34'h0_0000_001D, "resumed");
        $display("test timing done");
    endtask

    // user precision: points 1+1 shifted out, 8 bits kept, then extended
    task automatic t_user();
        cas(0, 32'hC8, 32'h4, 32'h4, 32'h0021_008E, 34'h3_FFFF_FFC9, "user s");
        cas(0, 32'hC8, 32'h4, 32'h0, 32'h0021_008A, 34'h0_0000_00C8, "user u");
        $display("test user done");
    endtask

    task automatic t_bus();
        logic [31:0] q;
        rd(0, 8'h1C, q);
        chk("unmapped data", q, 32'h0000_0000);
        wr(0, 8'h20, 32'h1234_5678);
        wr(0, mau_pkg::RESLO_OFS, 32'h1234_5678);
        res(0, 34'h0_0000_00C8, "ro write");
        wr(0, mau_pkg::OPC_OFS, 32'hAABB_CCDD, 4'h1);
        rd(0, mau_pkg::OPC_OFS, q);
        chk("byte lanes", q, 32'h0000_00DD);
        wr(0, mau_pkg::OPA_OFS, 32'hFFFF_1234);
        rd(0, mau_pkg::OPA_OFS, q);
        chk("opa width", q, 32'h0000_1234);
        rd(0, mau_pkg::STATUS_OFS, q);
        chk("primed", q, 32'h0000_033B);
        $display("test bus done");
    endtask

    task automatic t_modes();
        stat(1, 32'h0000_0001);
        cas(1, 32'h3, 32'h5, 32'h7, 32'h225, 34'h0_0000_0016, "fixed add");
        wr(1, mau_pkg::OPC_OFS, 32'h9);
        res(1, 34'h0_0000_0018, "comb path");
        stat(2, 32'h0000_0215);
        cas(2, 32'h3, 32'h5, 32'h7, 32'h224, 34'h0_0000_0008, "fixed sub");
        cas(2, 32'hC8, 32'h4, 32'h0, 32'h0021_008C, 34'h0_0000_0320, "float full");
        stat(3, 32'h0000_0032);
        cas(3, 32'h3, 32'h5, 32'h7, 32'h226, 34'h0_0000_0000, "refused fix");
        stat(4, 32'h0000_0036);
        cas(4, 32'h3, 32'h5, 32'h7, 32'h226, 34'h0_0000_0000, "refused flt");
        $display("test modes done");
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_arith();
        t_timing();
        t_user();
        t_bus();
        t_modes();
        test_done();
    end
endmodule
